// >>> ta_ctrl_consts.vh
// constants for the time alignment controller: register map, fields, timing
// assumes inclusion by the controller, its timer and the bench
`ifndef TA_CTRL_CONSTS_VH
`define TA_CTRL_CONSTS_VH

// one adjustment step and the clock rate
`define STEP_TIME_US 500
`define CLK_MHZ 25
`define STEP_CYCLES (`STEP_TIME_US * `CLK_MHZ)

// register byte offsets
`define A_CTRL 8'h00
`define A_SUP_LEN 8'h04
`define A_HOLD_LEN 8'h08
`define A_RETRY_LIM 8'h0c
`define A_STATUS 8'h10
`define A_INT_STAT 8'h14
`define A_INT_CLR 8'h18
`define A_INT_EN 8'h1c
`define A_LAST 8'h20

// control fields
`define CTRL_EN 0
`define CTRL_ERR_CLR 1
`define CTRL_UNBLOCK 2

// event bits, shared by status, clear and enable
`define EV_OK 0
`define EV_NOT_SUPP 1
`define EV_NOT_POSS 2
`define EV_TIMEOUT 3
`define EV_LOCAL_ERR 4
`define EV_W 5

// negative acknowledgement causes
`define CAUSE_NOT_SUPP 8'h01
`define CAUSE_NOT_POSS 8'h02

// reset values and timer width
`define SUP_LEN_RST 24'h0186a0
`define HOLD_LEN_RST 24'h030d40
`define RETRY_LIM_RST 4'h3
`define TMR_W 24

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> cycle_timer.v
// down counter that pulses once when a loaded length has elapsed
// assumes load and stop come from logic on the same clock
`timescale 1ns/1ps
`include "ta_ctrl_consts.vh"

module cycle_timer #(
	parameter W = `TMR_W
) (
	input wire aclk,
	input wire aresetn,
	input wire load,
	input wire stop,
	input wire [W-1:0] len,
	output wire running,
	output wire expire
);
	reg [W-1:0] cnt_ff;
	reg run_ff;
	reg exp_ff;

	assign running = run_ff;
	assign expire = exp_ff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff <= {W{1'b0}};
			run_ff <= 1'b0;
			exp_ff <= 1'b0;
		end else begin
			exp_ff <= 1'b0;
			if (stop) begin
				run_ff <= 1'b0;
			end else if (load) begin
				cnt_ff <= len;
				run_ff <= 1'b1;
			end else if (run_ff) begin
				// a zero length behaves as one cycle
				if (cnt_ff <= {{(W-1){1'b0}}, 1'b1}) begin
					run_ff <= 1'b0;
					exp_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// >>> iu_time_alignment_ctrl.v
// time alignment controller of the serving radio controller, axi4-lite slave
// assumes link strobes and need indication come from logic on aclk
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ta_ctrl_consts.vh"

module iu_time_alignment_ctrl #(
	parameter [`TMR_W-1:0] SUP_LEN_DEFAULT = `SUP_LEN_RST,
	parameter [`TMR_W-1:0] HOLD_LEN_DEFAULT = `HOLD_LEN_RST
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire need_align,
	input wire [7:0] need_steps,
	input wire data_suspended,
	input wire bearer_changed,
	output wire tx_valid,
	input wire tx_ready,
	output wire [7:0] tx_steps,
	input wire rx_ack,
	input wire rx_nack,
	input wire [7:0] rx_cause,
	output wire local_error,
	output wire irq
);
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_SEND = 3'h1;
	localparam [2:0] S_WAIT = 3'h2;
	localparam [2:0] S_HOLD = 3'h3;
	localparam [2:0] S_FAIL = 3'h4;

	reg [2:0] state_ff;
	reg [7:0] steps_ff;
	reg [7:0] cause_ff;
	reg [3:0] retry_ff;
	reg blocked_ff;
	reg en_ff;
	reg [`TMR_W-1:0] sup_len_ff;
	reg [`TMR_W-1:0] hold_len_ff;
	reg [3:0] retry_lim_ff;
	reg [`EV_W-1:0] int_stat_ff;
	reg [`EV_W-1:0] int_en_ff;

	// axi bookkeeping
	reg aw_hold_ff;
	reg w_hold_ff;
	reg [7:0] awaddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;
	reg bvalid_ff;
	reg [1:0] bresp_ff;
	reg rvalid_ff;
	reg [1:0] rresp_ff;
	reg [31:0] rdata_ff;

	wire sup_exp;
	wire hold_exp;
	wire sup_run;
	wire hold_run;

	// ---- register bus ----
	assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
	assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	wire wr_go = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
		{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	wire [31:0] wbits = wdata_ff & wmask;
	wire wr_ctrl = wr_go & (awaddr_ff == `A_CTRL);
	wire wr_iclr = wr_go & (awaddr_ff == `A_INT_CLR);
	wire err_clr = wr_ctrl & wbits[`CTRL_ERR_CLR];
	wire unblock = wr_ctrl & wbits[`CTRL_UNBLOCK];

	wire wr_known = (awaddr_ff == `A_CTRL) | (awaddr_ff == `A_SUP_LEN) |
		(awaddr_ff == `A_HOLD_LEN) | (awaddr_ff == `A_RETRY_LIM) |
		(awaddr_ff == `A_INT_CLR) | (awaddr_ff == `A_INT_EN);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// configuration registers; lanes merged by strobe
	always @(posedge aclk) begin
		if (!aresetn) begin
			en_ff <= 1'b0;
			sup_len_ff <= SUP_LEN_DEFAULT;
			hold_len_ff <= HOLD_LEN_DEFAULT;
			retry_lim_ff <= `RETRY_LIM_RST;
			int_en_ff <= {`EV_W{1'b0}};
		end else if (wr_go) begin
			case (awaddr_ff)
				`A_CTRL: begin
					if (wstrb_ff[0])
						en_ff <= wdata_ff[`CTRL_EN];
				end
				`A_SUP_LEN: begin
					sup_len_ff <= (sup_len_ff & ~wmask[`TMR_W-1:0]) | wbits[`TMR_W-1:0];
				end
				`A_HOLD_LEN: begin
					hold_len_ff <= (hold_len_ff & ~wmask[`TMR_W-1:0]) | wbits[`TMR_W-1:0];
				end
				`A_RETRY_LIM: begin
					if (wstrb_ff[0])
						retry_lim_ff <= wdata_ff[3:0];
				end
				`A_INT_EN: begin
					if (wstrb_ff[0])
						int_en_ff <= wdata_ff[`EV_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// read path, one cycle after address taken
	reg [31:0] rd_mux;
	reg rd_known;
	always @* begin
		rd_mux = 32'h00000000;
		rd_known = 1'b1;
		case ({s_axi_araddr[7:2], 2'b00})
			`A_CTRL: rd_mux = {31'h00000000, en_ff};
			`A_SUP_LEN: rd_mux = {8'h00, sup_len_ff};
			`A_HOLD_LEN: rd_mux = {8'h00, hold_len_ff};
			`A_RETRY_LIM: rd_mux = {28'h0000000, retry_lim_ff};
			`A_STATUS: rd_mux = {20'h00000, retry_ff, 1'b0, local_error,
				sup_run, blocked_ff, hold_run, state_ff};
			`A_INT_STAT: rd_mux = {27'h0000000, int_stat_ff};
			`A_INT_CLR: rd_mux = 32'h00000000;
			`A_INT_EN: rd_mux = {27'h0000000, int_en_ff};
			`A_LAST: rd_mux = {16'h0000, cause_ff, steps_ff};
			default: rd_known = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= `RESP_OKAY;
			rdata_ff <= 32'h00000000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_mux;
			rresp_ff <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ---- procedure ----
	wire in_wait = (state_ff == S_WAIT);
	// answers outside a pending command are stray and ignored
	wire got_ack = in_wait & rx_ack;
	wire got_nack = in_wait & rx_nack & ~rx_ack;
	wire nack_ns = got_nack & (rx_cause == `CAUSE_NOT_SUPP);
	wire nack_other = got_nack & ~nack_ns;
	wire timeout = in_wait & sup_exp & ~rx_ack & ~rx_nack;
	wire fail = nack_other | timeout;
	wire give_up = fail & (retry_ff >= retry_lim_ff);
	wire launch = en_ff & need_align & ~data_suspended & ~blocked_ff;

	assign tx_valid = (state_ff == S_SEND);
	assign tx_steps = steps_ff;
	assign local_error = (state_ff == S_FAIL);

	// supervision: loaded as the frame leaves, stopped by any answer
	cycle_timer #(
		.W(`TMR_W)
	) u_sup_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(tx_valid & tx_ready),
		.stop(got_ack | got_nack),
		.len(sup_len_ff),
		.running(sup_run),
		.expire(sup_exp)
	);

	// hold-off against timing oscillation
	cycle_timer #(
		.W(`TMR_W)
	) u_hold_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(got_ack),
		.stop(1'b0),
		.len(hold_len_ff),
		.running(hold_run),
		.expire(hold_exp)
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= S_IDLE;
			steps_ff <= 8'h00;
			cause_ff <= 8'h00;
			retry_ff <= 4'h0;
		end else begin
			if (got_nack)
				cause_ff <= rx_cause;
			case (state_ff)
				S_IDLE: begin
					if (launch) begin
						state_ff <= S_SEND;
						steps_ff <= need_steps;
					end
				end
				S_SEND: begin
					// payload held until the link takes it
					if (tx_ready)
						state_ff <= S_WAIT;
				end
				S_WAIT: begin
					// only one command pending; next waits for an outcome
					if (got_ack) begin
						state_ff <= S_HOLD;
						retry_ff <= 4'h0;
					end else if (nack_ns) begin
						state_ff <= S_IDLE;
					end else if (give_up) begin
						state_ff <= S_FAIL;
					end else if (fail) begin
						state_ff <= S_IDLE;
						retry_ff <= retry_ff + 4'h1;
					end
				end
				S_HOLD: begin
					if (hold_exp)
						state_ff <= S_IDLE;
				end
				S_FAIL: begin
					// stays until software has taken local action
					if (err_clr) begin
						state_ff <= S_IDLE;
						retry_ff <= 4'h0;
					end
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	// bearer block; a fresh refusal wins over a same-cycle change
	always @(posedge aclk) begin
		if (!aresetn)
			blocked_ff <= 1'b0;
		else if (nack_ns)
			blocked_ff <= 1'b1;
		else if (bearer_changed | unblock)
			blocked_ff <= 1'b0;
	end

	// ---- interrupts: sticky, set wins over clear ----
	wire [`EV_W-1:0] ev;
	assign ev[`EV_OK] = got_ack;
	assign ev[`EV_NOT_SUPP] = nack_ns;
	assign ev[`EV_NOT_POSS] = nack_other;
	assign ev[`EV_TIMEOUT] = timeout;
	assign ev[`EV_LOCAL_ERR] = give_up;

	wire [`EV_W-1:0] iclr = wr_iclr ? wbits[`EV_W-1:0] : {`EV_W{1'b0}};

	always @(posedge aclk) begin
		if (!aresetn)
			int_stat_ff <= {`EV_W{1'b0}};
		else
			int_stat_ff <= (int_stat_ff & ~iclr) | ev;
	end

	assign irq = |(int_stat_ff & int_en_ff);
endmodule

// >>> ta_ctrl_assertions.sv
// port checks on the time alignment controller
// assumes binding into iu_time_alignment_ctrl on one clock
`timescale 1ns/1ps
module ta_ctrl_checker (
	input wire aclk,
	input wire aresetn,
	input wire need_align,
	input wire data_suspended,
	input wire tx_valid,
	input wire tx_ready,
	input wire [7:0] tx_steps,
	input wire rx_ack,
	input wire rx_nack,
	input wire [7:0] rx_cause,
	input wire local_error,
	input wire s_axi_bvalid
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_steps_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_steps))
		else $error("steps moved");
	a_launch_cause: assert property ($rose(tx_valid) |-> $past(need_align) && !$past(data_suspended))
		else $error("bad launch");
	a_one_cmd: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("second command");
	a_err_quiet: assert property (local_error |-> !tx_valid)
		else $error("send in fail");
	a_fail_sticky: assert property (local_error |=> local_error || $rose(s_axi_bvalid))
		else $error("error dropped");
	a_hold_off: assert property (rx_ack |=> !tx_valid [*8])
		else $error("no hold-off");
	a_block_quiet: assert property (rx_nack && rx_cause == 8'h01 |=> !tx_valid [*8])
		else $error("not blocked");
	a_retrigger: assert property (rx_nack && rx_cause == 8'h02 && need_align && !data_suspended
		|-> ##[1:4] (tx_valid || local_error))
		else $error("no retry");
endmodule

bind iu_time_alignment_ctrl ta_ctrl_checker ta_ctrl_checker_inst (.*);

// >>> ta_core_node.sv
// core node model taking alignment commands
// assumes mode steady while a command is out; mode is also the delay
`timescale 1ns/1ps
module ta_core_node (
	input wire aclk,
	input wire aresetn,
	input wire tx_valid,
	input wire [1:0] mode,
	output logic tx_ready,
	output logic rx_ack,
	output logic rx_nack,
	output logic [7:0] rx_cause
);
	logic pend;
	logic [1:0] cnt;
	initial begin
		tx_ready = 1'b0;
		rx_ack = 1'b0;
		rx_nack = 1'b0;
		rx_cause = 8'h5a;
	end
	// mode 0 ack, 1 not supported, 2 not possible, 3 silent
	always @(posedge aclk) begin
		rx_ack <= 1'b0;
		rx_nack <= 1'b0;
		// cause is junk outside a refusal
		rx_cause <= rx_cause + 8'h35;
		if (!aresetn) begin
			tx_ready <= 1'b0;
			pend <= 1'b0;
			cnt <= 2'h0;
		end else if (tx_valid && tx_ready) begin
			tx_ready <= 1'b0;
			pend <= 1'b1;
			cnt <= 2'h0;
		end else if (tx_valid) begin
			tx_ready <= (cnt == mode);
			cnt <= cnt + 2'h1;
		end else if (pend) begin
			cnt <= cnt + 2'h1;
			if (cnt == mode) begin
				pend <= 1'b0;
				rx_ack <= (mode == 2'h0);
				rx_nack <= mode[0] ^ mode[1];
				if (mode[0] ^ mode[1]) rx_cause <= {6'h00, mode};
			end
		end
	end
endmodule

// >>> testbench.sv
// bench for the time alignment controller
// assumes the core node model and the bound checker
`timescale 1ns/1ps
`include "ta_ctrl_consts.vh"
module testbench;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, need_align = 0, data_suspended = 0;
	logic bearer_changed = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, tx_valid, tx_ready, rx_ack, rx_nack, local_error, irq, b, ta, tw;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, need_steps = 0, tx_steps, rx_cause;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, mode = 0, r;
	// mode, steps, expected events
	logic [23:0] rows [4] = '{24'h02fb04, 24'h037f08, 24'h000501, 24'h018002};
	integer num_errors = 0, num_checks = 0, i, n;
	always #20 aclk = ~aclk;
	iu_time_alignment_ctrl #(.SUP_LEN_DEFAULT(24'h000014), .HOLD_LEN_DEFAULT(24'h00001e))
		iu_time_alignment_ctrl_inst (.*);
	ta_core_node ta_core_node_inst (.*);
	task chk(input logic [33:0] seen, input logic [33:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		b = 0;
		while (!b) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
			tw = s_axi_wvalid & s_axi_wready;
			b = w ? s_axi_bvalid : s_axi_rvalid;
			r = w ? s_axi_bresp : s_axi_rresp;
			d = s_axi_rdata;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (ta) s_axi_arvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
			if (b) s_axi_rready <= 1'b0;
		end
	endtask
	// ends at the negedge before the frame is taken
	task take;
		do @(negedge aclk); while (!(tx_valid && tx_ready));
	endtask
	task end_sim;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge aclk);
		num_errors++;
		end_sim;
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid,
			tx_valid, local_error, irq}, 8'he0);
		bus(0, `A_SUP_LEN, 0);
		chk(d, 32'h14);
		bus(0, 8'h40, 0);
		chk({r, d}, {2'h2, 32'h0});
		bus(1, `A_STATUS, 0);
		chk(r, 2'h2);
		bus(1, `A_CTRL, 1);
		for (i = 0; i < 4; i++) begin
			mode <= rows[i][17:16];
			need_steps <= rows[i][15:8];
			need_align <= 1'b1;
			take;
			chk(tx_steps, rows[i][15:8]);
			@(posedge aclk);
			need_align <= 1'b0;
			repeat (60) @(posedge aclk);
			bus(0, `A_INT_STAT, 0);
			chk(d, rows[i][7:0]);
			bus(0, `A_LAST, 0);
			chk(d[7:0], rows[i][15:8]);
			bus(1, `A_INT_CLR, 32'h1f);
		end
		need_align <= 1'b1;
		mode <= 2'h0;
		repeat (12) @(negedge aclk);
		chk(tx_valid, 0);
		@(posedge aclk);
		bearer_changed <= 1'b1;
		@(posedge aclk);
		bearer_changed <= 1'b0;
		take;
		@(posedge aclk);
		// mode stays 0 until the node has sent its ack for this frame
		@(posedge aclk);
		mode <= 2'h2;
		n = 0;
		repeat (20) begin
			@(negedge aclk);
			if (tx_valid) n++;
		end
		chk(n, 0);
		@(posedge aclk);
		data_suspended <= 1'b1;
		n = 0;
		repeat (40) begin
			@(negedge aclk);
			if (tx_valid) n++;
		end
		chk(n, 0);
		@(posedge aclk);
		data_suspended <= 1'b0;
		n = 0;
		while (!local_error) begin
			@(negedge aclk);
			if (tx_valid && tx_ready) n++;
		end
		chk(n, 4);
		bus(0, `A_STATUS, 0);
		chk(d, 32'h344);
		@(posedge aclk);
		need_align <= 1'b0;
		bus(1, `A_INT_EN, 32'h10);
		@(negedge aclk);
		chk(irq, 1);
		bus(1, `A_INT_EN, 0);
		@(negedge aclk);
		chk(irq, 0);
		bus(1, `A_CTRL, 3);
		@(negedge aclk);
		chk(local_error, 0);
		bus(1, `A_INT_CLR, 32'h1f);
		bus(0, `A_INT_STAT, 0);
		chk(d, 0);
		end_sim;
	end
endmodule
